// >>> sipc_pkg.sv
// Package of instruction codes, privilege classes and carrier types for the privilege checker.
package sipc_pkg;

  localparam int unsigned PRIV_W = 2;
  localparam logic [PRIV_W-1:0] PRIV_KERNEL = 2'h0;
  localparam logic [PRIV_W-1:0] PRIV_USER   = 2'h3;

  // Encoding of the decoded system instruction presented by the front end.
  typedef enum logic [5:0] {
    SI_NONE                       = 6'h00,
    SI_HALT                       = 6'h01,
    SI_CLEAR_TASK_SWITCHED        = 6'h02,
    SI_CACHE_INVALIDATE           = 6'h03,
    SI_CACHE_WRITEBACK_INVALIDATE = 6'h04,
    SI_TLB_ENTRY_INVALIDATE       = 6'h05,
    SI_LOAD_GDT                   = 6'h06,
    SI_LOAD_IDT                   = 6'h07,
    SI_LOAD_LDT                   = 6'h08,
    SI_LOAD_TASK_REG              = 6'h09,
    SI_MOV_CONTROL_REG            = 6'h0a,
    SI_MACHINE_WORD_LOAD          = 6'h0b,
    SI_MOV_DEBUG_REG              = 6'h0c,
    SI_MSR_READ                   = 6'h0d,
    SI_MSR_WRITE                  = 6'h0e,
    SI_SEGMENT_BASE_SWAP          = 6'h0f,
    SI_FAST_SYSTEM_RETURN         = 6'h10,
    SI_LEGACY_FAST_EXIT           = 6'h11,
    SI_INT_FLAG_CLEAR             = 6'h12,
    SI_INT_FLAG_SET               = 6'h13,
    SI_PERF_COUNTER_READ          = 6'h14,
    SI_TIMESTAMP_READ             = 6'h15,
    SI_TIMESTAMP_ID_READ          = 6'h16,
    SI_BREAKPOINT                 = 6'h17,
    SI_INTERRUPT_RETURN           = 6'h18,
    SI_LOAD_ACCESS_RIGHTS         = 6'h19,
    SI_LOAD_SEGMENT_LIMIT         = 6'h1a,
    SI_ADJUST_REQ_LEVEL           = 6'h1b,
    SI_VERIFY_READ                = 6'h1c,
    SI_VERIFY_WRITE               = 6'h1d,
    SI_STORE_GDT                  = 6'h1e,
    SI_STORE_IDT                  = 6'h1f,
    SI_STORE_LDT                  = 6'h20,
    SI_STORE_TASK_REG             = 6'h21,
    SI_STORE_MACHINE_WORD         = 6'h22,
    SI_SMM_RETURN                 = 6'h23,
    SI_FAST_SYSTEM_CALL           = 6'h24,
    SI_LEGACY_FAST_ENTRY          = 6'h25,
    SI_UNDEFINED_OP               = 6'h26
  } sipc_instr_t;

  // Privilege class of a system instruction.
  typedef enum logic [2:0] {
    CLS_NONE   = 3'h1,
    CLS_KERNEL = 3'h2,
    CLS_OS     = 3'h4
  } sipc_class_t;

  // One decoded instruction offered for checking.
  typedef struct packed {
    logic              valid;
    sipc_instr_t       instr;
    logic [PRIV_W-1:0] current_privilege_level;
  } sipc_req_t;

  // Verdict on one checked instruction.
  typedef struct packed {
    logic        valid;
    sipc_instr_t instr;
    sipc_class_t cls;
    logic        execute;
    logic        gp_fault;
  } sipc_resp_t;

endpackage

// >>> sipc_check.sv
// Privilege checker for decoded system-management instructions.
// Behaviour
// - Privileged class executes only at level zero.
// - Halt, cache, TLB, table loads need level zero.
// - Control register moves, word load need zero.
// - Debug register moves, MSR access need zero.
// - Base swap, fast return, fast exit need zero.
// - Listed unprivileged instructions run at any level.
`timescale 1ns/1ps

module sipc_check
  import sipc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire sipc_req_t  req,
  input  wire logic       os_allow,
  output sipc_resp_t      resp
);

  // Decoding is combinational so that the verdict lands one cycle after the request.
  // One code to a line keeps a later move of a code between classes easy to audit.

  function automatic logic is_table_op(input sipc_instr_t i);
    unique case (i)
      SI_HALT:                       is_table_op = 1'b1;
      SI_CLEAR_TASK_SWITCHED:        is_table_op = 1'b1;
      SI_CACHE_INVALIDATE:           is_table_op = 1'b1;
      SI_CACHE_WRITEBACK_INVALIDATE: is_table_op = 1'b1;
      SI_TLB_ENTRY_INVALIDATE:       is_table_op = 1'b1;
      SI_LOAD_GDT:                   is_table_op = 1'b1;
      SI_LOAD_IDT:                   is_table_op = 1'b1;
      SI_LOAD_LDT:                   is_table_op = 1'b1;
      SI_LOAD_TASK_REG:              is_table_op = 1'b1;
      default:                       is_table_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_control_op(input sipc_instr_t i);
    unique case (i)
      SI_MOV_CONTROL_REG:   is_control_op = 1'b1;
      SI_MACHINE_WORD_LOAD: is_control_op = 1'b1;
      default:              is_control_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_debug_op(input sipc_instr_t i);
    unique case (i)
      SI_MOV_DEBUG_REG: is_debug_op = 1'b1;
      SI_MSR_READ:      is_debug_op = 1'b1;
      SI_MSR_WRITE:     is_debug_op = 1'b1;
      default:          is_debug_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_return_op(input sipc_instr_t i);
    unique case (i)
      SI_SEGMENT_BASE_SWAP:  is_return_op = 1'b1;
      SI_FAST_SYSTEM_RETURN: is_return_op = 1'b1;
      SI_LEGACY_FAST_EXIT:   is_return_op = 1'b1;
      default:               is_return_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_os_op(input sipc_instr_t i);
    unique case (i)
      SI_INT_FLAG_CLEAR:    is_os_op = 1'b1;
      SI_INT_FLAG_SET:      is_os_op = 1'b1;
      SI_PERF_COUNTER_READ: is_os_op = 1'b1;
      SI_TIMESTAMP_READ:    is_os_op = 1'b1;
      SI_TIMESTAMP_ID_READ: is_os_op = 1'b1;
      default:              is_os_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_free_op(input sipc_instr_t i);
    unique case (i)
      SI_BREAKPOINT:         is_free_op = 1'b1;
      SI_INTERRUPT_RETURN:   is_free_op = 1'b1;
      SI_LOAD_ACCESS_RIGHTS: is_free_op = 1'b1;
      SI_LOAD_SEGMENT_LIMIT: is_free_op = 1'b1;
      SI_ADJUST_REQ_LEVEL:   is_free_op = 1'b1;
      SI_VERIFY_READ:        is_free_op = 1'b1;
      SI_VERIFY_WRITE:       is_free_op = 1'b1;
      SI_STORE_GDT:          is_free_op = 1'b1;
      SI_STORE_IDT:          is_free_op = 1'b1;
      SI_STORE_LDT:          is_free_op = 1'b1;
      SI_STORE_TASK_REG:     is_free_op = 1'b1;
      SI_STORE_MACHINE_WORD: is_free_op = 1'b1;
      SI_SMM_RETURN:         is_free_op = 1'b1;
      SI_FAST_SYSTEM_CALL:   is_free_op = 1'b1;
      SI_LEGACY_FAST_ENTRY:  is_free_op = 1'b1;
      SI_UNDEFINED_OP:       is_free_op = 1'b1;
      default:               is_free_op = 1'b0;
    endcase
  endfunction

  // Group hits of the instruction on offer.
  logic        table_hit_w;
  logic        control_hit_w;
  logic        debug_hit_w;
  logic        return_hit_w;
  logic        kernel_hit_w;
  logic        os_hit_w;
  logic        free_hit_w;
  logic        unlisted_w;
  logic        level_zero_w;
  logic        kernel_ok_w;
  logic        os_ok_w;
  logic        free_ok_w;
  logic        allow_w;
  sipc_class_t cls_w;

  // Registered verdict, one register per field.
  logic        valid_d;
  logic        valid_q;
  sipc_instr_t instr_d;
  sipc_instr_t instr_q;
  sipc_class_t cls_d;
  sipc_class_t cls_q;
  logic        execute_d;
  logic        execute_q;
  logic        fault_d;
  logic        fault_q;

  assign table_hit_w   = is_table_op(req.instr);
  assign control_hit_w = is_control_op(req.instr);
  assign debug_hit_w   = is_debug_op(req.instr);
  assign return_hit_w  = is_return_op(req.instr);
  assign os_hit_w      = is_os_op(req.instr);
  assign free_hit_w    = is_free_op(req.instr);
  assign kernel_hit_w  = table_hit_w | control_hit_w | debug_hit_w | return_hit_w;
  // Codes outside every list are passed, as the gate only judges listed instructions.
  assign unlisted_w    = ~(kernel_hit_w | os_hit_w | free_hit_w);

  assign level_zero_w = (req.current_privilege_level == PRIV_KERNEL);
  assign kernel_ok_w  = kernel_hit_w & level_zero_w;
  // OS decides permission.
  // The permission arrives already resolved for the current level, so no level test here.
  assign os_ok_w      = os_hit_w & os_allow;
  assign free_ok_w    = free_hit_w | unlisted_w;
  assign allow_w      = kernel_ok_w | os_ok_w | free_ok_w;

  // Kernel wins over the OS class should a code ever sit in both lists.
  assign cls_w = kernel_hit_w ? CLS_KERNEL : (os_hit_w ? CLS_OS : CLS_NONE);

  // An idle slot gives neither grant nor fault, though instr and cls still follow the bus.
  assign valid_d   = req.valid;
  assign instr_d   = req.instr;
  assign cls_d     = cls_w;
  assign execute_d = req.valid & allow_w;
  // suppress and fault.
  // A refused OS-gated read faults too, since letting it run would leak the counter.
  assign fault_d   = req.valid & ~allow_w;

  // Synchronous reset clears the verdict so that no stale grant outlives it.
  always_ff @(posedge clock) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instr_q <= SI_NONE;
    end else begin
      instr_q <= instr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cls_q <= CLS_NONE;
    end else begin
      cls_q <= cls_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      execute_q <= 1'b0;
    end else begin
      execute_q <= execute_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // The output is a bare copy of the flops, with no logic after them.
  assign resp = '{
    valid:    valid_q,
    instr:    instr_q,
    cls:      cls_q,
    execute:  execute_q,
    gp_fault: fault_q
  };

endmodule

// >>> sipc_check_sva.sv
// Checker of the verdicts given by the privilege checker.
`timescale 1ns/1ps
module sipc_check_sva
  import sipc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire sipc_req_t  req,
  input wire logic       os_allow,
  input wire sipc_resp_t resp
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Codes are grouped by class in the package, so ranges stay short.
  wire k = req.valid && req.instr inside {[SI_HALT:SI_LEGACY_FAST_EXIT]};
  wire o = req.valid && req.instr inside {[SI_INT_FLAG_CLEAR:SI_TIMESTAMP_ID_READ]};
  wire u = req.current_privilege_level != PRIV_KERNEL;
  property p_zero; k && !u |=> resp.execute && !resp.gp_fault; endproperty
  a_zero: assert property (p_zero) else $error("denied at zero");
  property p_tbl; k && u && req.instr <= SI_LOAD_TASK_REG |=> !resp.execute; endproperty
  a_tbl: assert property (p_tbl) else $error("table op ran");
  property p_cr; k && req.instr inside {[SI_MOV_CONTROL_REG:SI_MACHINE_WORD_LOAD]}
    |=> resp.cls == CLS_KERNEL; endproperty
  a_cr: assert property (p_cr) else $error("bad class");
  property p_dr; k && u && req.instr inside {[SI_MOV_DEBUG_REG:SI_MSR_WRITE]}
    |=> resp.gp_fault; endproperty
  a_dr: assert property (p_dr) else $error("no fault");
  property p_sw; k && u && req.instr >= SI_SEGMENT_BASE_SWAP |=> resp.valid && !resp.execute;
  endproperty
  a_sw: assert property (p_sw) else $error("return ran");
  property p_os; o |=> resp.cls == CLS_OS && resp.execute == $past(os_allow); endproperty
  a_os: assert property (p_os) else $error("os gate wrong");
  property p_any; req.valid && !k && !o |=> resp.execute && resp.cls == CLS_NONE; endproperty
  a_any: assert property (p_any) else $error("free op held");
  property p_gp; k && u |=> resp.gp_fault && !resp.execute; endproperty
  a_gp: assert property (p_gp) else $error("no fault");
  property p_idle; !req.valid |=> !resp.valid && !resp.execute && !resp.gp_fault; endproperty
  a_idle: assert property (p_idle) else $error("idle slot acted");
  property p_rst; disable iff (1'b0) rst |=> !resp.valid && !resp.execute && !resp.gp_fault;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left verdict");
  c_gp: cover property (resp.gp_fault);
  c_os: cover property (resp.cls == CLS_OS && !resp.execute);
  c_ok: cover property (resp.execute && resp.cls == CLS_KERNEL);
endmodule

// >>> sipc_check_tb.sv
// Self-checking bench for the privilege checker.
`timescale 1ns/1ps
module sipc_check_tb;
  import sipc_pkg::*;
  logic       clock = 0;
  logic       rst = 1;
  logic       os_allow = 0;
  sipc_req_t  req = '0;
  sipc_resp_t resp;
  sipc_resp_t exp_q[$];
  int         fails = 0;
  int         checked = 0;
  int         cyc = 0;
  always #5 clock = ~clock;
  sipc_check dut (.clock(clock), .rst(rst), .req(req), .os_allow(os_allow), .resp(resp));
  function automatic sipc_resp_t model(sipc_req_t r, logic os);
    logic k, o, ok;
    k = r.instr inside {[SI_HALT:SI_LEGACY_FAST_EXIT]};
    o = r.instr inside {[SI_INT_FLAG_CLEAR:SI_TIMESTAMP_ID_READ]};
    ok = k ? r.current_privilege_level == PRIV_KERNEL : (!o || os);
    model = '{1'b1, r.instr, k ? CLS_KERNEL : (o ? CLS_OS : CLS_NONE), ok, !ok};
  endfunction
  task automatic cmp_resp(sipc_resp_t got);
    sipc_resp_t e;
    e = exp_q.size() ? exp_q.pop_front() : '0;
    checked++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED resp exp %h got %h", e, got);
    end
  endtask
  task automatic final_report();
    if (exp_q.size() != 0) begin
      fails++;
      $display("CHECK FAILED resp_count exp 0 got %0d", exp_q.size());
    end
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reads the value settled before this edge, so no race with the design.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (!rst && resp.valid === 1'b1) cmp_resp(resp);
    if (cyc == 2000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h5f5e));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 312; i++) begin
      sipc_req_t r;
      logic      os;
      r = '{i < 156 || $urandom_range(1), sipc_instr_t'(i % 39), PRIV_W'(i / 39)};
      os = 1'($urandom);
      @(posedge clock);
      req <= r;
      os_allow <= os;
      if (r.valid) exp_q.push_back(model(r, os));
    end
    @(posedge clock);
    req.valid <= 1'b0;
    repeat (3) @(posedge clock);
    $display("sweep of all codes and levels done");
    final_report();
  end
endmodule
bind sipc_check sipc_check_sva u_sva (.clock(clock), .rst(rst), .req(req),
  .os_allow(os_allow), .resp(resp));
